// ---- inc/uhi_pkg.sv ----
/*
 * constants shared by the interrupt flag and mask block of the usb host
 * controller: register codes, bit positions, reset values and widths.
 * assumes a plain register port that carries separate read and write codes.
 */
`default_nettype none

package uhi_pkg;

    // register port widths
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 32;

    // read and write codes of the registers
    localparam logic [7:0]  CMD_STAT_RD_ADDR  = 8'h02;
    localparam logic [7:0]  FLAGS_RD_ADDR     = 8'h03;
    localparam logic [7:0]  FLAGS_WR_ADDR     = 8'h83;
    localparam logic [7:0]  MASK_RD_ADDR      = 8'h04;
    localparam logic [7:0]  MASK_WR_ADDR      = 8'h84;

    // event flag positions, shared by the flag and mask registers
    localparam int unsigned EV_W              = 7;
    localparam int unsigned SCHED_OVR_BIT     = 0;
    localparam int unsigned FRAME_START_BIT   = 2;
    localparam int unsigned RESUME_BIT        = 3;
    localparam int unsigned FATAL_ERR_BIT     = 4;
    localparam int unsigned FRAME_WRAP_BIT    = 5;
    localparam int unsigned ROOT_CHANGE_BIT   = 6;
    localparam int unsigned GLOBAL_GATE_BIT   = 31;

    // bits that may ever hold a one; bit 1 never does, the fatal error bit only in the mask
    localparam logic [EV_W-1:0] FLAG_IMPL     = 7'h6D;
    localparam logic [EV_W-1:0] MASK_IMPL     = 7'h7D;

    // overrun tally field of the command and status register
    localparam int unsigned TALLY_W           = 2;
    localparam int unsigned TALLY_LSB         = 16;

    // root hub ports and width of each port's state word
    localparam int unsigned ROOT_PORTS        = 2;
    localparam int unsigned PORT_STATE_W      = 32;
    localparam int unsigned FRAME_NUM_W       = 16;

    // values after reset
    localparam logic [EV_W-1:0]    FLAGS_RST  = 7'h00;
    localparam logic [EV_W-1:0]    MASK_RST   = 7'h00;
    localparam logic               GATE_RST   = 1'b0;
    localparam logic [TALLY_W-1:0] TALLY_RST  = 2'h0;
    localparam logic [DATA_W-1:0]  RDATA_RST  = 32'h0000_0000;

endpackage : uhi_pkg

`default_nettype wire

// ---- verilog/uhi_change_det.sv ----
/*
 * change detector for a bus of levels, with a rising edge detector on its bit 0 only.
 * assumes the input is synchronous to ref_clk; no event is reported in the
 * first cycle after reset, since there is no earlier sample to compare with.
 */
`timescale 1ns/1ps
`default_nettype none

module uhi_change_det
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         soft_rst,
    input  wire logic [W-1:0] level,
    output logic              changed,
    output logic              rose
);

    logic [W-1:0] prev_q;
    logic         armed_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            prev_q <= '0;
        end
        else
        begin
            prev_q <= level;
        end
    end

    // comparisons wait for one real sample after any reset
    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            armed_q <= 1'b0;
        end
        else
        begin
            armed_q <= 1'b1;
        end
    end

    assign changed = armed_q && (prev_q != level);
    assign rose    = armed_q && !prev_q[0] && level[0];

endmodule // uhi_change_det

`default_nettype wire

// ---- verilog/uhi_irq_top.sv ----
/*
 * interrupt event flags, interrupt mask with global gate, overrun tally and
 * interrupt request of a full/low speed usb host controller.
 * assumes the register port master never reads and writes in one cycle and
 * that all event inputs are synchronous to ref_clk.
 * assumes sof_token_issued and schedule_overrun are high for one cycle per
 * event; every cycle in which they stand high counts as one more event.
 * assumes soft_rst comes from the controller's own software reset command;
 * it clears flags, mask, gate, tally and irq but leaves read data alone.
 * the mask-clear register, frame interval logic and root port logic sit
 * outside this block; only their results arrive on its pins.
 * reads of unmapped codes return zero and writes to them are dropped.
 */
// Added by the designer: the plain strobed port.
// Overview of operation
// R01 - each monitored event sets its flag, which stays set until software clears it
// R02 - irq asserts only while a flag, its mask bit and the global gate are set
// R03 - writing 1 to a flag bit clears it, writing 0 leaves it
// R04 - software writes can never set a flag
// R05 - mask bits mirror flag bits 0,2..6; bit 1 reserved
// R06 - any change of any root port state bit sets the root change flag
// R07 - a toggle of the frame counter msb sets the frame wrap flag
// R08 - the fatal system error flag always reads 0
// R09 - start of downstream resume signaling sets the resume flag
// R10 - software entering the resume state does not set the resume flag
// R11 - each frame start, with its token, sets the frame start flag
// R12 - an unfinished frame schedule sets the overrun flag
// R13 - each overrun also increments the two bit tally in command status
// R14 - writing 1 to a mask bit sets it, writing 0 leaves it
// R15 - reading the mask returns its contents, global gate included
// R16 - global gate is mask bit 31; 1 sets it, 0 has no effect
// R17 - tally starts at 0, wraps after 3, counts even with flag set
// R18 - flags, mask and gate reset to 0; reserved bits read 0, ignore writes
// R19 - irq follows its condition and drops within one clock of its removal
`timescale 1ns/1ps
`default_nettype none

module uhi_irq_top
    import uhi_pkg::*;
(
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst,
    input  wire logic                                 soft_rst,
    input  wire logic [ADDR_W-1:0]                    reg_addr,
    input  wire logic [DATA_W-1:0]                    reg_wdata,
    input  wire logic                                 reg_wr,
    input  wire logic                                 reg_rd,
    output logic      [DATA_W-1:0]                    reg_rdata,
    input  wire logic [ROOT_PORTS*PORT_STATE_W-1:0]   root_port_state,
    input  wire logic [FRAME_NUM_W-1:0]               frame_number,
    input  wire logic                                 downstream_resume,
    input  wire logic                                 sw_resume_entry,
    input  wire logic                                 sof_token_issued,
    input  wire logic                                 schedule_overrun,
    output logic                                      irq,
    output logic      [TALLY_W-1:0]                   overrun_tally
);

    // widen an event-position vector into its place in a 32-bit word
    function automatic logic [DATA_W-1:0] place_events(input logic [EV_W-1:0] ev);
        place_events = {{(DATA_W-EV_W){1'b0}}, ev};
    endfunction

    // register code hit by a write strobe
    function automatic logic write_hit(input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] code);
        write_hit = (addr == code);
    endfunction

    // read words of the three readable registers
    function automatic logic [DATA_W-1:0] flags_word(input logic [EV_W-1:0] fl);
        flags_word = place_events(fl & FLAG_IMPL);
    endfunction

    function automatic logic [DATA_W-1:0] mask_word(input logic [EV_W-1:0] mk,
                                                    input logic            gate);
        mask_word                  = place_events(mk);
        mask_word[GLOBAL_GATE_BIT] = gate;
    endfunction

    function automatic logic [DATA_W-1:0] cmd_word(input logic [TALLY_W-1:0] tally);
        cmd_word                       = RDATA_RST;
        cmd_word[TALLY_LSB +: TALLY_W] = tally;
    endfunction

    // register state
    logic [EV_W-1:0]    flags_q;
    logic [EV_W-1:0]    flags_d;
    logic [EV_W-1:0]    mask_q;
    logic [EV_W-1:0]    mask_d;
    logic               gate_q;
    logic               gate_d;
    logic [TALLY_W-1:0] tally_q;
    logic [TALLY_W-1:0] tally_d;
    logic [DATA_W-1:0]  rdata_q;
    logic [DATA_W-1:0]  rdata_d;
    logic               irq_q;
    logic               irq_d;
    logic [EV_W-1:0]    pending;

    // event detection
    logic               port_changed;
    logic               frame_msb_changed;
    logic               resume_rose;
    logic [EV_W-1:0]    ev_set;
    logic [EV_W-1:0]    ev_clr;

    // decoded strobes
    logic               flags_wr;
    logic               mask_wr;

    assign flags_wr = reg_wr && write_hit(reg_addr, FLAGS_WR_ADDR);
    assign mask_wr  = reg_wr && write_hit(reg_addr, MASK_WR_ADDR);

    // every bit of both root port words is watched; any change is one event
    uhi_change_det
    #(
        .W (ROOT_PORTS*PORT_STATE_W)
    )
    u_port_det
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .level    (root_port_state),
        .changed  (port_changed),
        .rose     ()
    );

    // only the frame counter msb matters; both directions count as a wrap
    uhi_change_det
    #(
        .W (1)
    )
    u_frame_det
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .level    (frame_number[FRAME_NUM_W-1]),
        .changed  (frame_msb_changed),
        .rose     ()
    );

    // resume is a level from the port; only its rising edge is an event
    uhi_change_det
    #(
        .W (1)
    )
    u_resume_det
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .soft_rst (soft_rst),
        .level    (downstream_resume),
        .changed  (),
        .rose     (resume_rose)
    );

    // collect this cycle's hardware events
    always_comb
    begin
        ev_set                  = '0;
        ev_set[ROOT_CHANGE_BIT] = port_changed;                     // [R06]
        ev_set[FRAME_WRAP_BIT]  = frame_msb_changed;                // [R07]
        ev_set[FATAL_ERR_BIT]   = 1'b0;                             // [R08]
        // only the far end's resume signaling counts, never a software entry
        ev_set[RESUME_BIT]      = resume_rose && !sw_resume_entry;  // [R09] [R10]
        ev_set[FRAME_START_BIT] = sof_token_issued;                 // [R11]
        ev_set[SCHED_OVR_BIT]   = schedule_overrun;                 // [R12]
    end

    // software write of ones clears; a zero leaves the flag alone
    always_comb
    begin
        ev_clr = '0;
        if (flags_wr)
        begin
            ev_clr = reg_wdata[EV_W-1:0];                           // [R03]
        end
    end

    // a new event in the clearing cycle wins; writes never set a flag
    always_comb
    begin
        flags_d = ((flags_q & ~ev_clr) | ev_set) & FLAG_IMPL;       // [R01] [R04] [R08]
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            flags_q <= FLAGS_RST;                                   // [R18]
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    // mask bits are write-one-to-set; only reset clears them here
    always_comb
    begin
        mask_d = mask_q;
        if (mask_wr)
        begin
            mask_d = mask_q | (reg_wdata[EV_W-1:0] & MASK_IMPL);    // [R14] [R05]
        end
    end

    // global gate shares the mask write code but sits in the top bit
    always_comb
    begin
        gate_d = gate_q;
        if (mask_wr)
        begin
            gate_d = gate_q | reg_wdata[GLOBAL_GATE_BIT];           // [R16]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            mask_q <= MASK_RST;                                     // [R18]
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            gate_q <= GATE_RST;                                     // [R18]
        end
        else
        begin
            gate_q <= gate_d;
        end
    end

    // overrun tally counts every overrun and wraps from 3 to 0
    always_comb
    begin
        tally_d = tally_q;
        if (schedule_overrun)
        begin
            tally_d = tally_q + 2'h1;                               // [R13] [R17]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            tally_q <= TALLY_RST;                                   // [R17]
        end
        else
        begin
            tally_q <= tally_d;
        end
    end

    // read data stand for one cycle after the read strobe
    always_comb
    begin
        rdata_d = RDATA_RST;
        if (reg_rd)
        begin
            case (reg_addr)
                FLAGS_RD_ADDR:
                begin
                    rdata_d = flags_word(flags_q);                  // [R18]
                end
                MASK_RD_ADDR:
                begin
                    rdata_d = mask_word(mask_q, gate_q);            // [R15]
                end
                CMD_STAT_RD_ADDR:
                begin
                    rdata_d = cmd_word(tally_q);                    // [R13]
                end
                default:
                begin
                    rdata_d = RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_q <= RDATA_RST;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // flags that software has chosen to hear about
    always_comb
    begin
        pending = flags_q & mask_q;
    end

    // request follows the gated flags with one register stage
    always_comb
    begin
        irq_d = gate_q && (pending != '0);                          // [R02]
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;                                         // [R19]
        end
    end

    assign reg_rdata     = rdata_q;
    assign irq           = irq_q;
    assign overrun_tally = tally_q;

endmodule // uhi_irq_top

`default_nettype wire

// ---- sim/uhi_irq_props.sv ----
/* port checker of the interrupt flag and mask block.
   assumes one clock domain and the port names of uhi_irq_top. */
`timescale 1ns/1ps
`default_nettype none
module uhi_irq_props
    import uhi_pkg::*;
(
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   soft_rst,
    input wire logic [ADDR_W-1:0]      reg_addr,
    input wire logic [DATA_W-1:0]      reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [DATA_W-1:0]      reg_rdata,
    input wire logic [FRAME_NUM_W-1:0] frame_number,
    input wire logic                   sof_token_issued,
    input wire logic                   schedule_overrun,
    input wire logic                   irq,
    input wire logic [TALLY_W-1:0]     overrun_tally
);
    logic [EV_W-1:0] mask_q;
    logic            gate_q;
    // shadow of the mask register, built from the writes seen
    always_ff @(posedge ref_clk)
    begin
        if (rst || soft_rst)
        begin
            mask_q <= MASK_RST;
            gate_q <= GATE_RST;
        end
        else if (reg_wr && reg_addr == MASK_WR_ADDR)
        begin
            mask_q <= mask_q | (reg_wdata[EV_W-1:0] & MASK_IMPL);
            gate_q <= gate_q | reg_wdata[GLOBAL_GATE_BIT];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || soft_rst);
    a_irq_needs_gate: assert property (irq |-> gate_q && mask_q != 7'h00)
        else $error("irq without gate or mask");
    a_sof_irq: assert property (sof_token_issued && gate_q && mask_q[FRAME_START_BIT] |-> ##2 irq)
        else $error("frame start gave no irq");
    a_wrap_irq: assert property ($changed(frame_number[15]) && gate_q && mask_q[FRAME_WRAP_BIT] |-> ##[1:3] irq)
        else $error("frame wrap gave no irq");
    a_tally_step: assert property (schedule_overrun |=> overrun_tally == $past(overrun_tally) + 2'h1)
        else $error("tally did not step");
    a_tally_hold: assert property (!schedule_overrun |=> $stable(overrun_tally))
        else $error("tally moved alone");
    a_mask_read: assert property ($past(reg_rd) && $past(reg_addr) == MASK_RD_ADDR |->
        reg_rdata == {gate_q, 24'h000000, mask_q}) else $error("mask read wrong");
    a_flags_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == FLAGS_RD_ADDR |->
        (reg_rdata & ~{25'h0000000, FLAG_IMPL}) == 32'h0000_0000) else $error("flag reserved bit set");
    a_cmd_read: assert property ($past(reg_rd) && $past(reg_addr) == CMD_STAT_RD_ADDR |->
        reg_rdata == {14'h0000, $past(overrun_tally), 16'h0000}) else $error("tally read wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read");
    c_irq: cover property ($rose(irq));
    c_wrap: cover property (schedule_overrun && overrun_tally == 2'h3);
    c_mask: cover property (gate_q && mask_q == MASK_IMPL);
endmodule // uhi_irq_props
bind uhi_irq_top uhi_irq_props u_props (.ref_clk, .rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .frame_number, .sof_token_issued, .schedule_overrun, .irq, .overrun_tally);
`default_nettype wire

// ---- sim/uhi_host_model.sv ----
/* host driver model: register port master with write and read tasks.
   assumes the register port of uhi_irq_top, no wait states. */
`timescale 1ns/1ps
`default_nettype none
module uhi_host_model
    import uhi_pkg::*;
(
    input  wire logic              ref_clk,
    output var logic [ADDR_W-1:0]  reg_addr,
    output var logic [DATA_W-1:0]  reg_wdata,
    output var logic               reg_wr,
    output var logic               reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // uhi_host_model
`default_nettype wire

// ---- sim/test_usb_host_irq_status_enable.sv ----
/* self-checking bench of the interrupt flag and mask block.
   assumes uhi_irq_top, the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_usb_host_irq_status_enable
    import uhi_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        soft_rst = 1'b0;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [63:0] root_port_state = '0;
    logic [15:0] frame_number = '0;
    logic        downstream_resume = 1'b0;
    logic        sw_resume_entry = 1'b0;
    logic        sof_token_issued = 1'b0;
    logic        schedule_overrun = 1'b0;
    logic        irq;
    logic [1:0]  overrun_tally;
    logic [31:0] rdv;
    int          miscompares = 0;
    int          comparisons = 0;
    always #5 ref_clk = ~ref_clk;
    uhi_irq_top DUT (.ref_clk, .rst, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .root_port_state, .frame_number, .downstream_resume, .sw_resume_entry, .sof_token_issued,
        .schedule_overrun, .irq, .overrun_tally);
    uhi_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic ev_chk(input logic [6:0] fl, input logic ie);
        repeat (4) @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, {31'h0, ie});
        rchk(FLAGS_RD_ADDR, {25'h0, fl});
        host.wr(FLAGS_WR_ADDR, 32'hFFFF_FFFF);
        @(posedge ref_clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        rchk(FLAGS_RD_ADDR, 32'h0);
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(FLAGS_RD_ADDR, 32'h0);
        rchk(MASK_RD_ADDR, 32'h0);
        rchk(CMD_STAT_RD_ADDR, 32'h0);
        rchk(8'h05, 32'h0);
        $display("test reset done");
        host.wr(MASK_WR_ADDR, 32'h0000_007F);
        rchk(MASK_RD_ADDR, 32'h0000_007D);
        @(posedge ref_clk) sof_token_issued <= 1'b1;
        @(posedge ref_clk) sof_token_issued <= 1'b0;
        ev_chk(7'h04, 1'b0);
        host.wr(MASK_WR_ADDR, 32'h8000_0000);
        host.wr(MASK_WR_ADDR, 32'h0);
        rchk(MASK_RD_ADDR, 32'h8000_007D);
        $display("test mask done");
        @(posedge ref_clk) sof_token_issued <= 1'b1;
        root_port_state <= 64'h1_0000_0000;
        @(posedge ref_clk) sof_token_issued <= 1'b0;
        repeat (3) @(posedge ref_clk);
        host.wr(FLAGS_WR_ADDR, 32'h0000_0004);
        ev_chk(7'h40, 1'b1);
        @(posedge ref_clk) schedule_overrun <= 1'b1;
        repeat (5) @(posedge ref_clk);
        schedule_overrun <= 1'b0;
        rchk(CMD_STAT_RD_ADDR, 32'h0001_0000);
        ev_chk(7'h01, 1'b1);
        $display("test events done");
        @(posedge ref_clk) frame_number <= 16'h7FFF;
        ev_chk(7'h00, 1'b0);
        @(posedge ref_clk) frame_number <= 16'h8000;
        ev_chk(7'h20, 1'b1);
        @(posedge ref_clk) frame_number <= 16'h0000;
        ev_chk(7'h20, 1'b1);
        @(posedge ref_clk) downstream_resume <= 1'b1;
        sw_resume_entry <= 1'b1;
        @(posedge ref_clk) sw_resume_entry <= 1'b0;
        ev_chk(7'h00, 1'b0);
        @(posedge ref_clk) downstream_resume <= 1'b0;
        repeat (2) @(posedge ref_clk);
        downstream_resume <= 1'b1;
        ev_chk(7'h08, 1'b1);
        $display("test frame and resume done");
        @(posedge ref_clk) soft_rst <= 1'b1;
        @(posedge ref_clk) soft_rst <= 1'b0;
        rchk(MASK_RD_ADDR, 32'h0);
        chk({30'h0, overrun_tally}, 32'h0);
        $display("test soft reset done");
        report_and_stop();
    end
endmodule // test_usb_host_irq_status_enable
`default_nettype wire
